/* circ_ctrl.sv */
// ir transceiver control: apb registers, event flags, interrupt, carrier, rx length limit
`timescale 1ns/10ps
`include "circ_params.svh"

module circ_ctrl
	import circ_pkg::*;
#(
	parameter int ADDR_W = 12 // apb address width
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event pulses from fifos and codec
	input wire logic rx_data_ready_evt,
	input wire logic rx_fifo_level_hit_evt,
	input wire logic rx_overflow_evt,
	input wire logic tx_fifo_empty_evt,
	input wire logic tx_level_hit_evt,
	input wire logic tx_underflow_evt,
	input wire logic min_length_detected_evt,
	// receive side
	input wire logic [7:0] rx_fifo_count,
	input wire logic rx_active,
	input wire logic rx_sample_stb,
	// transmit envelope from the encoder
	input wire logic tx_on,
	// results
	output logic tx_ir_out,
	output logic [1:0] sample_period_sel,
	output logic irq
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	circ_byte_t config_reg; // sample period select in bits 1:0
	circ_byte_t status_reg; // sticky event flags
	circ_byte_t irq_mask_reg; // interrupt enables, same layout
	logic mode_reg; // 1 selects pulse mode
	logic prescale_reg; // single prescaler bit
	// reserved prescale bits 6..1 keep no state and always read as zero
	circ_byte_t cycle_count_reg; // carrier period count
	circ_byte_t fill_level_reg; // sampled rx fifo count
	logic [15:0] limit_reg; // rx limit count, high and low bytes
	logic [15:0] rx_len_reg; // received length counter
	logic limit_hit_reg; // packet end already raised for this reception
	circ_bus_state_e bus_state_reg; // apb phase tracker
	logic [`CIRC_CARRIER_CNT_W-1:0] carrier_cnt_reg; // half period down counter
	logic carrier_phase_reg; // square wave of the carrier

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [3:0] reg_index; // word index of the access
	logic addr_valid; // index belongs to a register
	logic wr_commit; // write takes effect this edge
	logic rd_commit; // read data loads this edge
	logic rd_refuse; // refused read clears the read data
	logic [7:0] wbyte; // write data low byte

	// word aligned offsets only; anything above the low 16 words is unmapped
	// misaligned or high offsets must not alias a register, so they are refused
	assign reg_index = paddr[5:2];
	assign addr_valid = (paddr[ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0) &&
		((reg_index == `CIRC_IDX_CONFIG) || (reg_index == `CIRC_IDX_STATUS) ||
		(reg_index == `CIRC_IDX_IRQ_MASK) || (reg_index == `CIRC_IDX_PRESCALE) ||
		(reg_index == `CIRC_IDX_FILL_CYCLE) || (reg_index == `CIRC_IDX_LIMIT_HIGH) ||
		(reg_index == `CIRC_IDX_LIMIT_LOW));
	// the access phase samples pready high one cycle after it starts
	assign wr_commit = psel && penable && pwrite && addr_valid && (bus_state_reg == CIRC_BUS_WAIT);
	assign rd_commit = psel && penable && !pwrite && addr_valid &&
		(bus_state_reg == CIRC_BUS_IDLE);
	assign rd_refuse = psel && penable && !pwrite && !addr_valid &&
		(bus_state_reg == CIRC_BUS_IDLE);
	assign wbyte = pwdata[7:0];

	// ----------------------------------------------------------------
	// apb handshake: one wait state, pready from a flip-flop
	// ----------------------------------------------------------------
	// clock_en low holds the handshake too, so a frozen block stalls the bus
	// pslverr flags unmapped or misaligned offsets; writes there are dropped
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bus_state_reg <= CIRC_BUS_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clock_en) begin
			case (bus_state_reg)
				CIRC_BUS_IDLE: begin
					// access phase seen: answer on the next edge
					if (psel && penable) begin
						bus_state_reg <= CIRC_BUS_WAIT;
						pready <= 1'b1;
						pslverr <= !addr_valid;
					end
				end
				CIRC_BUS_WAIT: begin
					// transfer completes here, drop the answer
					bus_state_reg <= CIRC_BUS_DONE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				CIRC_BUS_DONE: begin
					// penable low for at least one cycle before the next access
					bus_state_reg <= CIRC_BUS_IDLE;
				end
				default: begin
					bus_state_reg <= CIRC_BUS_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read data mux, registered together with pready
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (clock_en) begin
			if (rd_commit) begin
				prdata <= 32'h00000000;
				case (reg_index)
					`CIRC_IDX_CONFIG: prdata[7:0] <= config_reg;
					`CIRC_IDX_STATUS: prdata[7:0] <= status_reg;
					`CIRC_IDX_IRQ_MASK: prdata[7:0] <= irq_mask_reg;
					// reserved bits 6..1 read as zero
					`CIRC_IDX_PRESCALE: begin
						prdata[`CIRC_CP_MODE_BIT] <= mode_reg;
						prdata[`CIRC_CP_PRESCALE_BIT] <= prescale_reg;
					end
					// shared offset: reads give the fifo count
					`CIRC_IDX_FILL_CYCLE: prdata[7:0] <= fill_level_reg;
					`CIRC_IDX_LIMIT_HIGH: prdata[7:0] <= limit_reg[15:8];
					`CIRC_IDX_LIMIT_LOW: prdata[7:0] <= limit_reg[7:0];
					default: prdata <= 32'h00000000;
				endcase
			end else if (rd_refuse) begin
				// refused read: zero even where the index aliases a register
				prdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// control registers written by software
	// ----------------------------------------------------------------
	// index 5 is shared: a write lands in the carrier count, never read back
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			config_reg <= `CIRC_RST_CONFIG;
			irq_mask_reg <= `CIRC_RST_BYTE;
			mode_reg <= 1'b0;
			prescale_reg <= 1'b0;
			cycle_count_reg <= `CIRC_RST_BYTE;
			limit_reg <= `CIRC_RST_LIMIT;
		end else if (clock_en) begin
			if (wr_commit) begin
				case (reg_index)
					`CIRC_IDX_CONFIG: config_reg <= wbyte;
					`CIRC_IDX_IRQ_MASK: irq_mask_reg <= wbyte;
					`CIRC_IDX_PRESCALE: begin
						mode_reg <= wbyte[`CIRC_CP_MODE_BIT];
						prescale_reg <= wbyte[`CIRC_CP_PRESCALE_BIT];
					end
					// shared offset: writes set the carrier period count
					`CIRC_IDX_FILL_CYCLE: cycle_count_reg <= wbyte;
					`CIRC_IDX_LIMIT_HIGH: limit_reg[15:8] <= wbyte;
					`CIRC_IDX_LIMIT_LOW: limit_reg[7:0] <= wbyte;
					default: config_reg <= config_reg;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// fifo count sampling
	// ----------------------------------------------------------------
	// the count is shown one cycle late: software sees a snapshot
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fill_level_reg <= `CIRC_RST_BYTE;
		end else if (clock_en) begin
			fill_level_reg <= rx_fifo_count;
		end
	end

	// ----------------------------------------------------------------
	// receive length counter against the limit
	// ----------------------------------------------------------------
	logic packet_end_evt; // one cycle pulse when length reaches the limit

	// counts samples while receiving; restarts once reception ends
	// the limit is compared with the count that this sample makes
	assign packet_end_evt = rx_active && rx_sample_stb && !limit_hit_reg &&
		((rx_len_reg + 16'h0001) == limit_reg);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rx_len_reg <= 16'h0000;
			limit_hit_reg <= 1'b0;
		end else if (clock_en) begin
			if (!rx_active) begin
				rx_len_reg <= 16'h0000;
				limit_hit_reg <= 1'b0;
			end else if (rx_sample_stb) begin
				rx_len_reg <= rx_len_reg + 16'h0001;
				if (packet_end_evt) begin
					limit_hit_reg <= 1'b1; // raise once per reception
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// sticky status flags, one generate slice per bit
	// ----------------------------------------------------------------
	logic [7:0] event_set; // set requests in status bit order
	logic [7:0] event_clear; // write-one clear requests

	// overrun also raises data ready in the same cycle
	assign event_set[`CIRC_EV_RX_DATA_READY] = rx_data_ready_evt || rx_overflow_evt;
	assign event_set[`CIRC_EV_RX_FIFO_LEVEL_HIT] = rx_fifo_level_hit_evt;
	assign event_set[`CIRC_EV_PACKET_END] = packet_end_evt;
	assign event_set[`CIRC_EV_RX_OVERFLOW] = rx_overflow_evt;
	assign event_set[`CIRC_EV_TX_FIFO_EMPTY] = tx_fifo_empty_evt;
	assign event_set[`CIRC_EV_TX_LEVEL_HIT] = tx_level_hit_evt;
	assign event_set[`CIRC_EV_TX_UNDERFLOW] = tx_underflow_evt;
	assign event_set[`CIRC_EV_MIN_LENGTH] = min_length_detected_evt;

	// a read never clears a flag, so polling software cannot lose an event
	// only a write of one to the status register clears; reads never do
	assign event_clear = (wr_commit && (reg_index == `CIRC_IDX_STATUS)) ? wbyte : 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			// set wins over a clear in the same cycle
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					status_reg[gi] <= 1'b0;
				end else if (clock_en) begin
					if (event_set[gi]) begin
						status_reg[gi] <= 1'b1;
					end else if (event_clear[gi]) begin
						status_reg[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	// registered, so irq follows a flag or mask change one cycle later
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else if (clock_en) begin
			irq <= |(status_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// carrier generator
	// ----------------------------------------------------------------
	// the shortest sample period forbids pulse mode; the led follows the envelope
	logic carrier_off; // prescale and count both zero
	logic pulse_allowed; // pulse mode selected and permitted
	logic [`CIRC_CARRIER_CNT_W-1:0] half_period; // 4^prescale * (count + 1)

	assign carrier_off = !prescale_reg && (cycle_count_reg == 8'h00);
	assign pulse_allowed = mode_reg && !carrier_off &&
		(config_reg[`CIRC_CFG_PERIOD_MSB:`CIRC_CFG_PERIOD_LSB] != `CIRC_CFG_PERIOD_1US);
	// full period is twice the half period
	// largest half period is 4 * 256, which fits the 11 bit counter
	assign half_period = prescale_reg ?
		(({3'h0, cycle_count_reg} + `CIRC_ONE_CYCLE) << `CIRC_PRESCALE_MULT_SHIFT) :
		({3'h0, cycle_count_reg} + `CIRC_ONE_CYCLE);

	// toggles the phase every half period, held low while idle
	// restarting when the envelope drops gives each burst a fresh phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			carrier_cnt_reg <= `CIRC_RST_CARRIER;
			carrier_phase_reg <= 1'b0;
		end else if (clock_en) begin
			if (!pulse_allowed || !tx_on) begin
				carrier_cnt_reg <= `CIRC_RST_CARRIER;
				carrier_phase_reg <= 1'b0;
			end else if (carrier_cnt_reg <= `CIRC_ONE_CYCLE) begin
				carrier_cnt_reg <= half_period;
				carrier_phase_reg <= !carrier_phase_reg;
			end else begin
				carrier_cnt_reg <= carrier_cnt_reg - `CIRC_ONE_CYCLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit pin and sample period output
	// ----------------------------------------------------------------
	// sample_period_sel hands the period choice to the receive sampler
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tx_ir_out <= 1'b0;
			sample_period_sel <= 2'h0;
		end else if (clock_en) begin
			// dc mode passes the envelope, pulse mode gates it with the carrier
			tx_ir_out <= pulse_allowed ? (tx_on && carrier_phase_reg) : tx_on;
			sample_period_sel <= config_reg[`CIRC_CFG_PERIOD_MSB:`CIRC_CFG_PERIOD_LSB];
		end
	end

endmodule

/* circ_params.svh */
// register map, field positions, reset values and timing counts of the ir control block
`ifndef CIRC_PARAMS_SVH
`define CIRC_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CIRC_IDX_CONFIG 4'h0
`define CIRC_IDX_STATUS 4'h1
`define CIRC_IDX_IRQ_MASK 4'h2
`define CIRC_IDX_PRESCALE 4'h4
`define CIRC_IDX_FILL_CYCLE 4'h5
`define CIRC_IDX_LIMIT_HIGH 4'h6
`define CIRC_IDX_LIMIT_LOW 4'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CIRC_EV_RX_DATA_READY 7
`define CIRC_EV_RX_FIFO_LEVEL_HIT 6
`define CIRC_EV_PACKET_END 5
`define CIRC_EV_RX_OVERFLOW 4
`define CIRC_EV_TX_FIFO_EMPTY 3
`define CIRC_EV_TX_LEVEL_HIT 2
`define CIRC_EV_TX_UNDERFLOW 1
`define CIRC_EV_MIN_LENGTH 0
`define CIRC_CP_MODE_BIT 7
`define CIRC_CP_PRESCALE_BIT 0
`define CIRC_CFG_PERIOD_MSB 1
`define CIRC_CFG_PERIOD_LSB 0
`define CIRC_CFG_PERIOD_1US 2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIRC_RST_BYTE 8'h00
`define CIRC_RST_CONFIG 8'h04
`define CIRC_RST_LIMIT 16'h0000
`define CIRC_RST_CARRIER 11'h000

// ----------------------------------------------------------------
// carrier timing: half period is 4^prescale * (count + 1) cycles
// ----------------------------------------------------------------
`define CIRC_CARRIER_CNT_W 11
`define CIRC_PRESCALE_MULT_SHIFT 2
`define CIRC_ONE_CYCLE 11'h001

`endif

/* circ_pkg.sv */
// types shared by the ir control block
package circ_pkg;

	// apb transfer phase of the register slave
	typedef enum logic [1:0] {
		CIRC_BUS_IDLE,
		CIRC_BUS_WAIT,
		CIRC_BUS_DONE
	} circ_bus_state_e;

	// byte wide register word
	typedef logic [7:0] circ_byte_t;

endpackage

/* circ_ctrl_checker.sv */
// port checks of the ir control block
`timescale 1ns/10ps
module circ_ctrl_checker (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_on,
	input wire logic tx_ir_out,
	input wire logic [1:0] sample_period_sel,
	input wire logic irq
);
	logic wr_now; // write access phase on the bus
	logic [3:0] wr_d; // recent write phases, bounds the irq and select latency
	assign wr_now = psel && penable && pwrite;
	// four cycles of write history
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_d <= 4'h0;
		end else begin
			wr_d <= {wr_d[2:0], wr_now};
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_in_time_a: assert property (psel && penable && !pready |-> ##[1:3] pready)
		else $error("access not answered");
	refused_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	irq_sticky_a: assert property ($fell(irq) |-> |wr_d)
		else $error("irq dropped without a write");
	led_gate_a: assert property (!tx_on |=> !tx_ir_out)
		else $error("led lit without envelope");
	no_pulse_1us_a: assert property (
		tx_on && sample_period_sel == 2'h0 ##1 sample_period_sel == 2'h0 |-> tx_ir_out)
		else $error("led modulated in the shortest sample period");
	sel_by_write_a: assert property ($changed(sample_period_sel) |-> |wr_d)
		else $error("sample period moved without a write");
	irq_seen_c: cover property ($rose(irq));
	refused_seen_c: cover property (pready && pslverr);
	carrier_seen_c: cover property (tx_on && $fell(tx_ir_out));
endmodule

bind circ_ctrl circ_ctrl_checker u_circ_ctrl_checker (.clock, .reset, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .tx_on, .tx_ir_out, .sample_period_sel, .irq);

/* circ_ir_far.sv */
// far side model: receiver dongle sending length units, and led watcher
`timescale 1ns/10ps
module circ_ir_far (
	input wire logic clock,
	input wire logic reset,
	input wire logic go,
	input wire logic [7:0] units,
	input wire logic led_in,
	output logic rx_active,
	output logic rx_sample_stb,
	output logic [15:0] high_len,
	output logic [15:0] lit_run
);
	logic [7:0] left; // units still to send
	logic [1:0] gap; // slow pacing, one unit every four cycles
	logic led_d; // led level one cycle ago
	// frame of units; line idles low between frames
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			left <= 8'h00;
			gap <= 2'h0;
			rx_sample_stb <= 1'b0;
		end else begin
			gap <= gap + 2'h1;
			rx_sample_stb <= 1'b0;
			if (go) begin
				left <= units;
			end else if (left != 8'h00 && gap == 2'h3) begin
				left <= left - 8'h01;
				rx_sample_stb <= 1'b1;
			end
		end
	end
	assign rx_active = (left != 8'h00) || rx_sample_stb;
	// length of lit runs seen on the led
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			led_d <= 1'b0;
			lit_run <= 16'h0000;
			high_len <= 16'h0000;
		end else begin
			led_d <= led_in;
			lit_run <= led_in ? lit_run + 16'h0001 : 16'h0000;
			if (led_d && !led_in) high_len <= lit_run;
		end
	end
endmodule

/* circ_ctrl_tb_top.sv */
// self-checking bench of the ir control block
`timescale 1ns/10ps
module circ_ctrl_tb_top;
	logic clock = 1'b0; // 50 ns block clock
	logic reset = 1'b1; // async reset
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat, crow;
	logic pready, pslverr, rerr, tx_ir_out, irq, rx_active, rx_sample_stb;
	logic go = 1'b0, tx_on = 1'b0; // frame start, transmit envelope
	logic [1:0] sample_period_sel;
	logic [7:0] ev = 8'h00, rx_fifo_count = 8'h00, units = 8'h00, es;
	logic [15:0] high_len, lit_run;
	int n_mismatch = 0, num_checks = 0;
	// rows: write flag, address, write data, expected read
	logic [28:0] rows [17] = '{29'h0000004, 29'h0040000, 29'h0080000, 29'h0100000,
		29'h0140000, 29'h0180000, 29'h01C0000, 29'h1008A500, 29'h00800A5, 29'h10181200,
		29'h0180012, 29'h101C3400, 29'h01C0034, 29'h10108000, 29'h0100080, 29'h10000100,
		29'h0000001};
	// carrier rows: prescale, count, config, lit run (0 when steady)
	logic [31:0] carrier [6] = '{32'h80020103, 32'h81010208, 32'h80000100, 32'h81000304,
		32'h80020000, 32'h00020100};
	logic [11:0] bad [3] = '{12'h00C, 12'h020, 12'h009}; // unmapped or misaligned
	always #25 clock = ~clock;
	circ_ctrl u_circ_ctrl (.clock, .reset, .clock_en(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_data_ready_evt(ev[7]),
		.rx_fifo_level_hit_evt(ev[6]), .rx_overflow_evt(ev[4]), .tx_fifo_empty_evt(ev[3]),
		.tx_level_hit_evt(ev[2]), .tx_underflow_evt(ev[1]), .min_length_detected_evt(ev[0]),
		.rx_fifo_count, .rx_active, .rx_sample_stb, .tx_on, .tx_ir_out, .sample_period_sel,
		.irq);
	circ_ir_far u_circ_ir_far (.clock, .reset, .go, .units, .led_in(tx_ir_out), .rx_active,
		.rx_sample_stb, .high_len, .lit_run);
	// count a comparison, report a mismatch
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// pready is sampled at the rising edge; only the watchdog ends a hang
		do @(posedge clock); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// verdict and end of run
	task automatic end_of_test;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		foreach (rows[i]) begin
			apb(rows[i][28], rows[i][27:16], {24'h0, rows[i][15:8]});
			if (!rows[i][28]) chk("register", {24'h0, rows[i][7:0]}, rdat);
		end
		chk("period select", 32'h1, {30'h0, sample_period_sel});
		foreach (bad[i]) begin
			apb(1'b0, bad[i], 32'h0);
			chk("refused", 32'h1, {31'h0, rerr});
			chk("refused data", 32'h0, rdat);
		end
		// each event but packet end masked, zero-write kept, enabled, then cleared by one
		for (int i = 0; i < 8; i++) begin
			if (i == 5) continue;
			es = (i == 4) ? 8'h90 : 8'h01 << i;
			apb(1'b1, 12'h008, {24'h0, ~es});
			ev[i] <= 1'b1;
			@(posedge clock);
			ev <= 8'h00;
			apb(1'b1, 12'h004, 32'h0);
			chk("irq masked", 32'h0, {31'h0, irq});
			apb(1'b0, 12'h004, 32'h0);
			chk("status", {24'h0, es}, rdat);
			apb(1'b1, 12'h008, 32'hFF);
			repeat (3) @(negedge clock);
			chk("irq enabled", 32'h1, {31'h0, irq});
			apb(1'b1, 12'h004, {24'h0, es});
			repeat (3) @(negedge clock);
			chk("irq cleared", 32'h0, {31'h0, irq});
		end
		// reset in mid-run with a flag standing
		ev[0] <= 1'b1;
		@(posedge clock);
		ev <= 8'h00;
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		chk("irq after reset", 32'h0, {31'h0, irq});
		apb(1'b0, 12'h004, 32'h0);
		chk("status after reset", 32'h0, rdat);
		chk("irq after release", 32'h0, {31'h0, irq});
		// frames of two and three units against a limit of three
		apb(1'b1, 12'h01C, 32'h3);
		for (int n = 2; n < 4; n++) begin
			units <= 8'(n);
			go <= 1'b1;
			@(posedge clock);
			go <= 1'b0;
			@(negedge clock);
			for (int k = 0; k < 40 && rx_active !== 1'b0; k++) @(negedge clock);
			apb(1'b0, 12'h004, 32'h0);
			chk("packet end", (n == 3) ? 32'h20 : 32'h0, rdat);
		end
		rx_fifo_count <= 8'h5A;
		apb(1'b0, 12'h014, 32'h0);
		chk("fill level", 32'h5A, rdat);
		// carrier settings against the lit run on the led
		tx_on <= 1'b1;
		foreach (carrier[i]) begin
			crow = carrier[i];
			apb(1'b1, 12'h010, {24'h0, crow[31:24]});
			apb(1'b1, 12'h014, {24'h0, crow[23:16]});
			apb(1'b1, 12'h000, {24'h0, crow[15:8]});
			repeat (240) @(negedge clock);
			if (crow[7:0] == 8'h00) begin
				chk("steady", 32'h1, {31'h0, lit_run > 16'h00C8});
			end else begin
				chk("lit run", {24'h0, crow[7:0]}, {16'h0, high_len});
			end
		end
		end_of_test;
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		end_of_test;
	end
endmodule
